//--- hdl/drc_refresh_xm.v
/*
 * DRAM refresh engine and external master strobe generator.
 * Assumes: one clock mclk_i; rst_i is the master reset (synchronous, high);
 * pins from the external bus pass two flip-flops; core signals share mclk_i.
 */
// Behaviour
// - Refresh is CAS-before-RAS on both banks
// - DRAM transfers delay refresh; others never do
// - Zero field: 65536 clocks, else N times 16
// - Piled-up requests yield one refresh only
// - Rate write reloads counter, requests once
// - Refresh holds off DRAM transfers through precharge
// - No bus request while refresh runs
// - Master reset aborts refresh, clears rate
// - Normal reset leaves refresh running
// - Capture address, direction, width on start
// - Refresh continues while external master owns bus
// - Data bus undriven when not bus master
// - Row waits for refresh and precharge
// - Refresh waits for external DRAM transfer
// - Acknowledge each transfer and subtransfer
// - Drive row then column when enabled
// - Address undriven when drive enable clear
// - No address drive for non-DRAM regions
// - Fastest nonburst transfer takes five clocks
// - Row, strobe, column, acknowledge sequence
`timescale 1ns/100ps
`include "drc_regs.vh"

module drc_refresh_xm #(
	parameter [27:0] DRAM_BASE = 28'h0000000,
	parameter [27:0] DRAM_MASK = 28'hF000000,
	parameter integer BANK_BIT = 23
) (
	// Clock and master reset
	input wire mclk_i,
	input wire rst_i,
	// AXI4-Lite register port
	input wire [3:0] axi_awaddr_i,
	input wire axi_awvalid_i,
	output reg axi_awready_o,
	input wire [31:0] axi_wdata_i,
	input wire [3:0] axi_wstrb_i,
	input wire axi_wvalid_i,
	output reg axi_wready_o,
	output reg [1:0] axi_bresp_o,
	output reg axi_bvalid_o,
	input wire axi_bready_i,
	input wire [3:0] axi_araddr_i,
	input wire axi_arvalid_i,
	output reg axi_arready_o,
	output reg [31:0] axi_rdata_o,
	output reg [1:0] axi_rresp_o,
	output reg axi_rvalid_o,
	input wire axi_rready_i,
	// Internal core side
	input wire core_dram_req_i,
	input wire core_dram_busy_i,
	input wire core_bus_owner_i,
	input wire core_data_drive_i,
	output reg bus_request_o,
	output reg core_hold_o,
	output reg data_oe_o,
	// External bus pins
	input wire norm_rst_n_i,
	input wire bus_granted_i,
	input wire transfer_start_n_i,
	input wire [27:0] addr_i,
	input wire rw_i,
	input wire [1:0] xfer_width_i,
	output reg [27:0] addr_o,
	output reg addr_oe_o,
	output reg transfer_ack_n_o,
	output reg transfer_ack_oe_o,
	// DRAM strobes
	output reg [1:0] ras_n_o,
	output reg [3:0] cas_n_o,
	output reg dram_write_strobe_n_o
);

	////////////////////////////////////////////////////////////////////////////////
	// States
	localparam [8:0] ST_IDLE = 9'h001;
	localparam [8:0] ST_REF_CAS = 9'h002;
	localparam [8:0] ST_REF_RAS = 9'h004;
	localparam [8:0] ST_PRECH = 9'h008;
	localparam [8:0] ST_XM_ROW = 9'h010;
	localparam [8:0] ST_XM_RAS = 9'h020;
	localparam [8:0] ST_XM_COL = 9'h040;
	localparam [8:0] ST_XM_ACK = 9'h080;
	localparam [8:0] ST_XM_END = 9'h100;

	////////////////////////////////////////////////////////////////////////////////
	// Functions
	function [3:0] port_bytes;
		input [1:0] port;
		begin
			case (port)
				`DRC_PORT_8: port_bytes = 4'h1;
				`DRC_PORT_16: port_bytes = 4'h2;
				default: port_bytes = 4'h4;
			endcase
		end
	endfunction

	// Beats of one transfer, less one
	function [3:0] beats_m1;
		input [1:0] port;
		input [1:0] sz;
		reg [4:0] bytes;
		begin
			bytes = 5'h04;
			case (sz)
				`DRC_SZ_BYTE: bytes = 5'h01;
				`DRC_SZ_WORD: bytes = 5'h02;
				`DRC_SZ_LINE: bytes = 5'h10;
				default: bytes = 5'h04;
			endcase
			case (port)
				`DRC_PORT_8: beats_m1 = bytes[3:0] - 4'h1;
				`DRC_PORT_16: beats_m1 = (bytes[4:1] == 4'h0) ? 4'h0 : bytes[4:1] - 4'h1;
				default: beats_m1 = (bytes[4:2] == 3'h0) ? 4'h0 : {1'b0, bytes[4:2]} - 4'h1;
			endcase
		end
	endfunction

	// Column strobes, lane 3 is the top byte of the data bus
	function [3:0] cas_lanes;
		input [1:0] port;
		input [1:0] sz;
		input [1:0] a;
		begin
			case (port)
				`DRC_PORT_8: cas_lanes = 4'h8;
				`DRC_PORT_16: cas_lanes = (sz == `DRC_SZ_BYTE) ? (a[0] ? 4'h4 : 4'h8) : 4'hC;
				default: begin
					if (sz == `DRC_SZ_BYTE)
						cas_lanes = 4'h8 >> a;
					else if (sz == `DRC_SZ_WORD)
						cas_lanes = a[1] ? 4'h3 : 4'hC;
					else
						cas_lanes = 4'hF;
				end
			endcase
		end
	endfunction

	function is_dram;
		input [27:0] a;
		begin
			is_dram = ((a & DRAM_MASK) == (DRAM_BASE & DRAM_MASK));
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	reg [33:0] pin_s1_r;
	reg [33:0] pin_s2_r;
	always @(posedge mclk_i) begin
		pin_s1_r <= {norm_rst_n_i, bus_granted_i, transfer_start_n_i, rw_i, xfer_width_i, addr_i};
		pin_s2_r <= pin_s1_r;
	end
	wire norm_rst_s = ~pin_s2_r[33];
	wire granted_s = pin_s2_r[32];
	wire ts_s = ~pin_s2_r[31];
	wire rw_s = pin_s2_r[30];
	wire [1:0] sz_s = pin_s2_r[29:28];
	wire [27:0] addr_s = pin_s2_r[27:0];

	////////////////////////////////////////////////////////////////////////////////
	// Registers and bus slave
	reg [`DRC_RC_W-1:0] rate_r;
	reg [`DRC_TIM_W-1:0] timing_r;
	reg [3:0] awaddr_r;
	reg aw_held_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg w_held_r;
	reg rate_wr_r;
	reg [8:0] state_r;
	reg ref_pend_r;
	reg xm_pend_r;
	reg [2:0] prech_cnt_r;

	wire [2:0] rcd = timing_r[`DRC_TIM_RCD_MSB:`DRC_TIM_RCD_LSB];
	wire [1:0] rp = timing_r[`DRC_TIM_RP_MSB:`DRC_TIM_RP_LSB];
	wire ade = timing_r[`DRC_TIM_ADE_BIT];
	wire [1:0] port = timing_r[`DRC_TIM_PORT_MSB:`DRC_TIM_PORT_LSB];
	wire ref_busy = state_r[1] | state_r[2];
	wire xm_busy = |state_r[8:4];
	wire wr_go = aw_held_r & w_held_r & ~axi_bvalid_o;
	wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	wire [31:0] rate_new = ({20'h00000, rate_r} & ~wmask) | (wdata_r & wmask);
	wire [31:0] tim_new = ({21'h000000, timing_r} & ~wmask) | (wdata_r & wmask);

	// Master reset clears both programmable registers
	always @(posedge mclk_i) begin
		if (rst_i) begin
			axi_awready_o <= 1'b0;
			axi_wready_o <= 1'b0;
			axi_bvalid_o <= 1'b0;
			axi_bresp_o <= `DRC_RESP_OKAY;
			axi_arready_o <= 1'b0;
			axi_rvalid_o <= 1'b0;
			axi_rresp_o <= `DRC_RESP_OKAY;
			axi_rdata_o <= 32'h00000000;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 4'h0;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			rate_r <= `DRC_RATE_RST;
			timing_r <= `DRC_TIM_RST;
			rate_wr_r <= 1'b0;
		end else begin
			rate_wr_r <= 1'b0;
			axi_awready_o <= ~aw_held_r & ~axi_awready_o & axi_awvalid_i;
			if (axi_awvalid_i & axi_awready_o) begin
				aw_held_r <= 1'b1;
				awaddr_r <= axi_awaddr_i;
			end
			axi_wready_o <= ~w_held_r & ~axi_wready_o & axi_wvalid_i;
			if (axi_wvalid_i & axi_wready_o) begin
				w_held_r <= 1'b1;
				wdata_r <= axi_wdata_i;
				wstrb_r <= axi_wstrb_i;
			end
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				axi_bvalid_o <= 1'b1;
				axi_bresp_o <= `DRC_RESP_OKAY;
				case ({awaddr_r[3:2], 2'b00})
					`DRC_OFS_REFRESH_RATE: begin
						rate_r <= rate_new[`DRC_RC_W-1:0];
						rate_wr_r <= 1'b1;
					end
					`DRC_OFS_DRAM_TIMING: timing_r <= tim_new[`DRC_TIM_W-1:0];
					`DRC_OFS_STATUS: ;
					default: axi_bresp_o <= `DRC_RESP_SLVERR;
				endcase
			end else if (axi_bvalid_o & axi_bready_i) begin
				axi_bvalid_o <= 1'b0;
			end
			axi_arready_o <= ~axi_rvalid_o & ~axi_arready_o & axi_arvalid_i;
			if (axi_arvalid_i & axi_arready_o) begin
				axi_rvalid_o <= 1'b1;
				axi_rresp_o <= `DRC_RESP_OKAY;
				case ({axi_araddr_i[3:2], 2'b00})
					`DRC_OFS_REFRESH_RATE: axi_rdata_o <= {20'h00000, rate_r};
					`DRC_OFS_DRAM_TIMING: axi_rdata_o <= {21'h000000, timing_r};
					`DRC_OFS_STATUS: axi_rdata_o <= {27'h0000000, xm_pend_r, prech_cnt_r != 3'h0,
						xm_busy, ref_pend_r, ref_busy};
					default: begin
						axi_rdata_o <= 32'h00000000;
						axi_rresp_o <= `DRC_RESP_SLVERR;
					end
				endcase
			end else if (axi_rvalid_o & axi_rready_i) begin
				axi_rvalid_o <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Refresh interval counter
	reg [15:0] ref_cnt_r;
	wire [15:0] ref_reload = (rate_r == 12'h000) ? `DRC_REF_SLOW_RELOAD :
		{rate_r, 4'h0} - 16'h0001;
	wire ref_tick = (ref_cnt_r == 16'h0000);

	always @(posedge mclk_i) begin
		if (rst_i)
			ref_cnt_r <= `DRC_REF_SLOW_RELOAD;
		else if (rate_wr_r | ref_tick)
			ref_cnt_r <= ref_reload;
		else
			ref_cnt_r <= ref_cnt_r - 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transfer engine
	reg [27:0] xm_addr_r;
	reg xm_rw_r;
	reg [1:0] xm_sz_r;
	reg [3:0] beat_r;
	reg [2:0] wait_r;
	// Ending a refresh loads precharge so the next row waits for it
	wire [2:0] prech_load = `DRC_PRECH_MIN + {1'b0, rp};
	wire row_ok = (prech_cnt_r == 3'h0) & ~ref_pend_r;
	wire [27:0] col_addr = {xm_addr_r[18:0], xm_addr_r[8:0]};
	wire bank = xm_addr_r[BANK_BIT];

	always @(posedge mclk_i) begin
		if (rst_i) begin
			// Master reset aborts any refresh
			state_r <= ST_IDLE;
			ref_pend_r <= 1'b0;
			xm_pend_r <= 1'b0;
			prech_cnt_r <= 3'h0;
			xm_addr_r <= 28'h0000000;
			xm_rw_r <= 1'b1;
			xm_sz_r <= `DRC_SZ_LONG;
			beat_r <= 4'h0;
			wait_r <= 3'h0;
			addr_o <= 28'h0000000;
			addr_oe_o <= 1'b0;
			transfer_ack_n_o <= 1'b1;
			transfer_ack_oe_o <= 1'b0;
			ras_n_o <= 2'h3;
			cas_n_o <= 4'hF;
			dram_write_strobe_n_o <= 1'b1;
			bus_request_o <= 1'b0;
			core_hold_o <= 1'b0;
			data_oe_o <= 1'b0;
		end else begin
			// Several ticks while waiting collapse into one pending flag
			if (ref_tick | (rate_wr_r & ~ref_busy))
				ref_pend_r <= 1'b1;
			if (prech_cnt_r != 3'h0)
				prech_cnt_r <= prech_cnt_r - 3'h1;
			// A start is only noticed while the bus is granted away
			if (granted_s & ts_s & ~xm_busy & ~xm_pend_r & is_dram(addr_s)) begin
				xm_pend_r <= 1'b1;
				xm_addr_r <= addr_s;
				xm_rw_r <= rw_s;
				xm_sz_r <= sz_s;
			end
			// Core waits through refresh and its precharge
			core_hold_o <= ref_busy | state_r[3] | (state_r[0] & ref_pend_r);
			bus_request_o <= core_dram_req_i & ~core_bus_owner_i & ~ref_busy & ~state_r[3];
			data_oe_o <= core_bus_owner_i & core_data_drive_i;
			case (state_r)
				ST_IDLE: begin
					transfer_ack_oe_o <= 1'b0;
					// Refresh goes ahead unless a DRAM transfer or precharge is active
					if (ref_pend_r & ~core_dram_busy_i & (prech_cnt_r == 3'h0)) begin
						ref_pend_r <= ref_tick; // keeps a tick of this very cycle
						cas_n_o <= 4'h0;
						state_r <= ST_REF_CAS;
					end else if (xm_pend_r & row_ok & ~core_dram_busy_i) begin
						xm_pend_r <= 1'b0;
						beat_r <= beats_m1(port, xm_sz_r);
						state_r <= ST_XM_ROW;
					end
				end
				ST_REF_CAS: begin
					ras_n_o <= 2'h0; // Both banks together
					wait_r <= `DRC_REF_RAS_MIN + rcd;
					state_r <= ST_REF_RAS;
				end
				ST_REF_RAS: begin
					if (wait_r == 3'h1) begin
						ras_n_o <= 2'h3;
						cas_n_o <= 4'hF;
						prech_cnt_r <= prech_load;
						state_r <= ST_PRECH;
					end else begin
						wait_r <= wait_r - 3'h1;
					end
				end
				ST_PRECH: begin
					if (prech_cnt_r <= 3'h1)
						state_r <= ST_IDLE;
				end
				ST_XM_ROW: begin
					// Row strobe only once precharge is met
					if (prech_cnt_r == 3'h0) begin
						addr_o <= xm_addr_r;
						addr_oe_o <= ade;
						dram_write_strobe_n_o <= xm_rw_r;
						wait_r <= rcd;
						state_r <= ST_XM_RAS;
					end
				end
				ST_XM_RAS: begin
					// One cycle stands for the half clock before the row strobe
					ras_n_o[bank] <= 1'b0;
					state_r <= ST_XM_COL;
				end
				ST_XM_COL: begin
					if (wait_r == 3'h0) begin
						addr_o <= col_addr;
						transfer_ack_oe_o <= 1'b1;
						transfer_ack_n_o <= 1'b1;
						cas_n_o <= ~cas_lanes(port, xm_sz_r, xm_addr_r[1:0]);
						state_r <= ST_XM_ACK;
					end else begin
						wait_r <= wait_r - 3'h1;
					end
				end
				ST_XM_ACK: begin
					transfer_ack_n_o <= 1'b0;
					state_r <= ST_XM_END;
				end
				ST_XM_END: begin
					// Fastest path row to end is five clocks
					transfer_ack_n_o <= 1'b1;
					ras_n_o <= 2'h3;
					cas_n_o <= 4'hF;
					prech_cnt_r <= prech_load;
					if (beat_r != 4'h0) begin
						// Burst beats reopen the row after precharge
						beat_r <= beat_r - 4'h1;
						xm_addr_r <= xm_addr_r + {24'h000000, port_bytes(port)};
						state_r <= ST_XM_ROW;
					end else begin
						addr_oe_o <= 1'b0;
						dram_write_strobe_n_o <= 1'b1;
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
			// Normal reset drops external work but never a refresh
			if (norm_rst_s & ~ref_busy & ~state_r[3]) begin
				xm_pend_r <= 1'b0;
				if (xm_busy) begin
					state_r <= ST_IDLE;
					addr_oe_o <= 1'b0;
					transfer_ack_oe_o <= 1'b0;
					transfer_ack_n_o <= 1'b1;
					ras_n_o <= 2'h3;
					cas_n_o <= 4'hF;
					dram_write_strobe_n_o <= 1'b1;
				end
			end
		end
	end

endmodule // drc_refresh_xm

//--- inc/drc_regs.vh
/*
 * Register map, field positions, reset values and timing counts of the
 * DRAM refresh and external master block.
 * Assumes: included by the design file by bare name; 32-bit AXI4-Lite words.
 */
`ifndef DRC_REGS_VH
`define DRC_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define DRC_OFS_REFRESH_RATE 4'h0
`define DRC_OFS_DRAM_TIMING 4'h4
`define DRC_OFS_STATUS 4'h8

////////////////////////////////////////////////////////////////////////////////
// Refresh rate register: refresh_interval_field in bits 11:0
`define DRC_RC_W 12
`define DRC_RATE_RST 12'h000

// Timing register fields
`define DRC_TIM_W 11
`define DRC_TIM_RST 11'h000
`define DRC_TIM_RCD_LSB 0
`define DRC_TIM_RCD_MSB 2
`define DRC_TIM_RP_LSB 4
`define DRC_TIM_RP_MSB 5
`define DRC_TIM_ADE_BIT 8
`define DRC_TIM_PORT_LSB 9
`define DRC_TIM_PORT_MSB 10

// Port width codes
`define DRC_PORT_32 2'h0
`define DRC_PORT_8 2'h1
`define DRC_PORT_16 2'h2

// Transfer width codes
`define DRC_SZ_LONG 2'h0
`define DRC_SZ_BYTE 2'h1
`define DRC_SZ_WORD 2'h2
`define DRC_SZ_LINE 2'h3

////////////////////////////////////////////////////////////////////////////////
// Refresh interval: zero field gives the slow count, else field times unit
`define DRC_REF_SLOW_RELOAD 16'hFFFF
`define DRC_REF_UNIT_SHIFT 4
// Least row precharge and refresh row strobe width, in clocks
`define DRC_PRECH_MIN 3'h1
`define DRC_REF_RAS_MIN 3'h2

// AXI responses
`define DRC_RESP_OKAY 2'h0
`define DRC_RESP_SLVERR 2'h2

`endif

//--- test/drc_refresh_xm_sva.sv
/* Pin-level checks of the refresh engine and external master strobes.
   Assumes: bound into drc_refresh_xm; one clock, synchronous high reset. */
`timescale 1ns/100ps
module drc_refresh_xm_sva (
	// Clock and reset
	input wire mclk_i,
	input wire rst_i,
	// Core side
	input wire core_bus_owner_i,
	input wire bus_request_o,
	input wire core_hold_o,
	input wire data_oe_o,
	// Pins
	input wire addr_oe_o,
	input wire transfer_ack_n_o,
	input wire transfer_ack_oe_o,
	input wire [1:0] ras_n_o,
	input wire [3:0] cas_n_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence row_lead;
		$rose(addr_oe_o) && ras_n_o == 2'b11;
	endsequence
	sequence ack_end;
		!transfer_ack_n_o ##1 transfer_ack_n_o && ras_n_o == 2'b11;
	endsequence
	////////////////////////////////////////
	both_banks_a: assert property ($fell(ras_n_o[0]) && $past(cas_n_o) == 4'h0 |-> ras_n_o == 2'b00)
		else $error("refresh missed a bank");
	row_first_a: assert property (row_lead |=> ras_n_o != 2'b11)
		else $error("row strobe late");
	ack_close_a: assert property ($fell(transfer_ack_n_o) |-> ack_end)
		else $error("acknowledge not one cycle");
	ack_driven_a: assert property (!transfer_ack_n_o |-> transfer_ack_oe_o && cas_n_o != 4'hF)
		else $error("acknowledge without column");
	ack_negated_a: assert property ($rose(transfer_ack_oe_o) |-> transfer_ack_n_o ##[1:12] !transfer_ack_n_o)
		else $error("acknowledge not driven negated first");
	no_busreq_a: assert property (ras_n_o == 2'b00 |=> !bus_request_o)
		else $error("bus request during refresh");
	hold_core_a: assert property (ras_n_o == 2'b00 |=> core_hold_o)
		else $error("core not held off");
	data_float_a: assert property (!core_bus_owner_i |=> !data_oe_o)
		else $error("data driven without bus");
	reset_idle_a: assert property ($fell(rst_i) |-> ras_n_o == 2'b11 && cas_n_o == 4'hF && !addr_oe_o)
		else $error("strobes active after reset");
endmodule // drc_refresh_xm_sva

bind drc_refresh_xm drc_refresh_xm_sva chk (.*);

//--- test/drc_xm_partner.sv
/* Foreign bus master that starts single transfers and watches the answer.
   Assumes: the bench resolves the shared address wire into bus_i. */
`timescale 1ns/100ps
module drc_xm_partner (
	// Clock and observed pins
	input wire mclk_i,
	input wire [27:0] bus_i,
	input wire addr_oe_i,
	input wire ack_n_i,
	input wire ack_oe_i,
	// Driven pins
	output reg ts_n_o,
	output reg [27:0] addr_o,
	output reg rw_o,
	output reg [1:0] width_o
);
	initial begin
		ts_n_o = 1'b1;
		addr_o = 28'h0000000;
		rw_o = 1'b1;
		width_o = 2'h0;
	end
	task xfer(input [27:0] a, input w, input [1:0] sz, output ack, output [27:0] row, output [27:0] col,
		output integer n);
		integer i;
		begin
			@(posedge mclk_i);
			ts_n_o <= 1'b0;
			addr_o <= a;
			rw_o <= w;
			width_o <= sz;
			@(posedge mclk_i);
			ts_n_o <= 1'b1;
			// Released pins float; inverse value stops a stale match
			addr_o <= ~a;
			ack = 1'b0;
			n = 0;
			row = 28'h0000000;
			col = 28'h0000000;
			for (i = 0; i < 24 && !ack; i++) begin
				@(negedge mclk_i);
				if (addr_oe_i && n == 0)
					row = bus_i;
				if (addr_oe_i)
					n++;
				if (ack_oe_i && !ack_n_i) begin
					ack = 1'b1;
					col = bus_i;
				end
			end
		end
	endtask
endmodule // drc_xm_partner

//--- test/test_drc_refresh_xm.sv
/* Self-checking bench for the refresh engine and external master logic.
   Assumes: drc_refresh_xm with default region parameters. */
`timescale 1ns/100ps
`include "drc_regs.vh"
module test_drc_refresh_xm;
	reg mclk_i = 1'b0;
	reg rst_i = 1'b1;
	reg [3:0] axi_awaddr_i = 4'h0;
	reg axi_awvalid_i = 1'b0;
	reg [31:0] axi_wdata_i = 32'h0;
	reg [3:0] axi_wstrb_i = 4'hF;
	reg axi_wvalid_i = 1'b0;
	reg axi_bready_i = 1'b0;
	reg [3:0] axi_araddr_i = 4'h0;
	reg axi_arvalid_i = 1'b0;
	reg axi_rready_i = 1'b0;
	reg core_dram_req_i = 1'b1;
	reg core_dram_busy_i = 1'b0;
	reg core_bus_owner_i = 1'b0;
	reg core_data_drive_i = 1'b1;
	reg norm_rst_n_i = 1'b1;
	reg bus_granted_i = 1'b0;
	wire transfer_start_n_i, rw_i, axi_awready_o, axi_wready_o, axi_bvalid_o, axi_arready_o, axi_rvalid_o;
	wire bus_request_o, core_hold_o, data_oe_o, addr_oe_o, transfer_ack_n_o, transfer_ack_oe_o;
	wire dram_write_strobe_n_o;
	wire [1:0] xfer_width_i, axi_bresp_o, axi_rresp_o, ras_n_o;
	wire [27:0] addr_i, addr_o, pm_addr;
	wire [31:0] axi_rdata_o;
	wire [3:0] cas_n_o;
	reg [31:0] d;
	reg [1:0] r;
	reg ack, dn;
	reg [27:0] row, col;
	integer num_errors = 0, n_tests = 0, cyc = 0, rf_cnt = 0, rf_last = 0, rf_per = 0, n, s, k;
	// Address wire level from both drivers
	assign addr_i = addr_oe_o ? addr_o : pm_addr;
	drc_refresh_xm dut (.*);
	drc_xm_partner pm (.mclk_i(mclk_i), .bus_i(addr_i), .addr_oe_i(addr_oe_o), .ack_n_i(transfer_ack_n_o),
		.ack_oe_i(transfer_ack_oe_o), .ts_n_o(transfer_start_n_i), .addr_o(pm_addr), .rw_o(rw_i),
		.width_o(xfer_width_i));
	always #5 mclk_i = ~mclk_i;
	// A refresh shows as one cycle of all columns low with rows idle
	always @(negedge mclk_i) begin
		cyc++;
		if (cas_n_o == 4'h0 && ras_n_o == 2'b11) begin
			rf_cnt++;
			rf_per = cyc - rf_last;
			rf_last = cyc;
		end
	end
	////////////////////////////////////////
	task check(input [31:0] seen, input [31:0] exp, input string nm);
		begin
			n_tests++;
			if (seen !== exp) begin
				num_errors++;
				$display("BAD %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", n_tests, num_errors);
			if (num_errors == 0 && n_tests > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task ticks(input integer c);
		repeat (c) @(posedge mclk_i);
	endtask
	task do_reset;
		begin
			rst_i <= 1'b1;
			ticks(16);
			rst_i <= 1'b0;
			ticks(2);
		end
	endtask
	task axi_wr(input [3:0] a, input [31:0] v);
		integer i;
		begin
			@(posedge mclk_i);
			axi_awaddr_i <= a;
			axi_wdata_i <= v;
			axi_awvalid_i <= 1'b1;
			axi_wvalid_i <= 1'b1;
			axi_bready_i <= 1'b1;
			dn = 1'b0;
			for (i = 0; i < 40 && !dn; i++) begin
				@(posedge mclk_i);
				if (axi_awready_o) axi_awvalid_i <= 1'b0;
				if (axi_wready_o) axi_wvalid_i <= 1'b0;
				if (axi_bvalid_o) begin
					axi_bready_i <= 1'b0;
					r = axi_bresp_o;
					dn = 1'b1;
				end
			end
			check(dn, 1, "write answer");
		end
	endtask
	task axi_rd(input [3:0] a);
		integer i;
		begin
			@(posedge mclk_i);
			axi_araddr_i <= a;
			axi_arvalid_i <= 1'b1;
			axi_rready_i <= 1'b1;
			dn = 1'b0;
			for (i = 0; i < 40 && !dn; i++) begin
				@(posedge mclk_i);
				if (axi_arready_o) axi_arvalid_i <= 1'b0;
				if (axi_rvalid_o) begin
					axi_rready_i <= 1'b0;
					d = axi_rdata_o;
					r = axi_rresp_o;
					dn = 1'b1;
				end
			end
			check(dn, 1, "read answer");
		end
	endtask
	////////////////////////////////////////
	task t_rate;
		for (k = 1; k < 4; k++) begin
			do_reset;
			s = rf_cnt;
			axi_wr(`DRC_OFS_REFRESH_RATE, k);
			ticks(8);
			check(rf_cnt - s, 1, "write refresh");
			ticks(k * 32 + 24);
			check(rf_per, k * 16, "period");
		end
		$display("rate test done");
	endtask
	task t_pend;
		begin
			do_reset;
			core_dram_busy_i <= 1'b1;
			s = rf_cnt;
			axi_wr(`DRC_OFS_REFRESH_RATE, 8);
			axi_wr(`DRC_OFS_REFRESH_RATE, 8);
			ticks(150);
			check(rf_cnt - s, 0, "held refresh");
			core_dram_busy_i <= 1'b0;
			ticks(30);
			check(rf_cnt - s, 1, "single refresh");
			$display("pending test done");
		end
	endtask
	task t_ext;
		begin
			do_reset;
			bus_granted_i <= 1'b1;
			axi_wr(`DRC_OFS_DRAM_TIMING, 32'h100);
			pm.xfer(28'h0ABCDEF, 1'b1, `DRC_SZ_LONG, ack, row, col, n);
			check(ack, 1, "ack");
			check(row, 28'h0ABCDEF, "row");
			check(col, {4'h0, 19'h3CDEF, 9'h1EF}, "column");
			check(n + 1, 5, "length");
			ticks(4);
			axi_wr(`DRC_OFS_DRAM_TIMING, 32'h0);
			pm.xfer(28'h0123456, 1'b0, `DRC_SZ_BYTE, ack, row, col, n);
			check(ack, 1, "ack plain");
			check(n, 0, "undriven");
			ticks(4);
			pm.xfer(28'h1000000, 1'b1, `DRC_SZ_WORD, ack, row, col, n);
			check({ack, n[7:0]}, 0, "other region");
			axi_wr(`DRC_OFS_REFRESH_RATE, 1);
			norm_rst_n_i <= 1'b0;
			ticks(8);
			s = rf_cnt;
			ticks(64);
			check(rf_cnt - s, 4, "refresh in reset");
			norm_rst_n_i <= 1'b1;
			$display("external test done");
		end
	endtask
	task t_mreset;
		begin
			rst_i <= 1'b1;
			ticks(2);
			s = rf_cnt;
			ticks(14);
			check(rf_cnt, s, "reset refresh");
			rst_i <= 1'b0;
			ticks(2);
			axi_rd(`DRC_OFS_REFRESH_RATE);
			check(d, 0, "rate");
			axi_rd(`DRC_OFS_DRAM_TIMING);
			check(d, 0, "timing");
			axi_rd(4'hC);
			check(32'(r), `DRC_RESP_SLVERR, "read unmapped");
			axi_wr(4'hC, 32'h5);
			check(32'(r), `DRC_RESP_SLVERR, "write unmapped");
			$display("reset test done");
		end
	endtask
	initial begin
		#200000;
		num_errors++;
		wrap_up;
	end
	initial begin
		do_reset;
		t_rate;
		t_pend;
		t_ext;
		t_mreset;
		wrap_up;
	end
endmodule // test_drc_refresh_xm
